/* File: inc/iosel_consts.svh */
// constants of the i/o setting and stop select block
`ifndef IOSEL_CONSTS_SVH
`define IOSEL_CONSTS_SVH
`define IOSEL_NREG        27
`define IOSEL_NPARAM      26
`define IOSEL_IDX_AUTO    5'd0
`define IOSEL_IDX_IN0     5'd1
`define IOSEL_IDX_OUT1    5'd14
`define IOSEL_IDX_FILT    5'd18
`define IOSEL_IDX_STOP    5'd19
`define IOSEL_IDX_FACA    5'd20
`define IOSEL_IDX_FACB    5'd22
`define IOSEL_IDX_FACC    5'd24
`define IOSEL_IDX_FACD    5'd25
`define IOSEL_IDX_STAT    5'd26
`define IOSEL_RST_TABLE   {16'h0000, 16'h262d, 16'h0303, 16'h2003, 16'h0202, 16'h0202, \
                           16'h0d06, 16'h2c0d, 16'h070a, 16'h0707, 16'h080b, 16'h0808, \
                           16'h0505, 16'h0505, 16'h0003, 16'h0004, 16'h0002, 16'h0005, \
                           16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, \
                           16'h0000, 16'h0000}
`define IOSEL_STOP_DIG_LSB  2'd0
`define IOSEL_RES_DIG_LSB   2'd1
`define IOSEL_RTI_DIG_LSB   2'd2
`define IOSEL_FN_FWD      8'h0a
`define IOSEL_FN_REV      8'h0b
`define IOSEL_FN_RES      8'h0d
`define IOSEL_AUTO_FWD    0
`define IOSEL_AUTO_REV    1
`define IOSEL_AUTO_RES    2
`define IOSEL_RTI_CODE    4'hf
`define IOSEL_FILT_TICK_NS  1000
`define IOSEL_CLK_NS        4
`define IOSEL_FILT_TICK_CYC ((`IOSEL_FILT_TICK_NS) / (`IOSEL_CLK_NS))
`define IOSEL_RESP_OKAY   2'b00
`define IOSEL_RESP_SLVERR 2'b10
`endif

/* File: inc/iosel_pkg.sv */
// types of the i/o setting and stop select block
package iosel_pkg;
  typedef logic [15:0] iosel_word_type;
  typedef enum logic [1:0] {
    IOSEL_RUN    = 2'b00,
    IOSEL_SLOW   = 2'b01,
    IOSEL_SUDDEN = 2'b10
  } iosel_stop_type;
endpackage

/* File: logic/iosel_top.sv */
// i/o setting parameter bank with stop, reset and ride-through selection
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`include "iosel_consts.svh"
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
module iosel_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // drive power cycle
  input  wire logic        power_cycle,
  // digital pins
  input  wire logic [6:0]  di_pin,
  output logic [3:0]       do_pin,
  // drive side status
  input  wire logic        soft_limit_hit,
  input  wire logic        servo_on_req,
  input  wire logic        overload_ride,
  input  wire logic        power_fail_ride,
  input  wire logic [15:0] status_in,
  input  wire logic [15:0] point_decel,
  // drive side controls
  output logic             forward_stroke_end,
  output logic             reverse_stroke_end,
  output logic             reset_input,
  output logic             stop_sudden,
  output logic             stop_slow,
  output logic [15:0]      decel_time,
  output logic             power_stage_on,
  output logic             ride_through_indicator
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  localparam logic [16*`IOSEL_NPARAM-1:0] RST_TABLE = `IOSEL_RST_TABLE;
  localparam logic [8:0] FILT_TICK = 9'(`IOSEL_FILT_TICK_CYC);

  // reset value of a parameter word
  function automatic iosel_pkg::iosel_word_type rst_val(input logic [4:0] idx);
    rst_val = RST_TABLE[16*(`IOSEL_NPARAM-1-int'(idx)) +: 16];
  endfunction

  // four-bit digit of a word, digit zero in the low bits
  function automatic logic [3:0] digit(input iosel_pkg::iosel_word_type w,
                                       input logic [1:0] n);
    digit = w[4*n +: 4];
  endfunction

  // word index from a byte address, out of range gives all ones
  function automatic logic [4:0] addr_idx(input logic [7:0] a);
    addr_idx = (a[7:2] < 6'(`IOSEL_NREG)) ? a[6:2] : 5'h1f;
  endfunction

  function automatic logic is_factory(input logic [4:0] idx);
    is_factory = (idx == `IOSEL_IDX_FACA) || (idx == `IOSEL_IDX_FACB) ||
                 (idx == `IOSEL_IDX_FACC) || (idx == `IOSEL_IDX_FACD);
  endfunction

  // --------------------------------------------------------------------------
  // parameter storage
  // --------------------------------------------------------------------------
  iosel_pkg::iosel_word_type pend [`IOSEL_NPARAM];
  iosel_pkg::iosel_word_type act  [`IOSEL_NPARAM];
  iosel_pkg::iosel_stop_type stop_state;
  iosel_pkg::iosel_stop_type next_stop_state;

  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic [4:0]  w_idx;
  logic [4:0]  r_idx;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign w_idx         = addr_idx(aw_addr);
  assign r_idx         = addr_idx(s_axi_araddr);

  // address and data are caught in either order
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response, error for unmapped words only, read-only words answer okay
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `IOSEL_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (w_idx < 5'(`IOSEL_NREG)) ? `IOSEL_RESP_OKAY : `IOSEL_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // pending words take writes, live words load on power cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < `IOSEL_NPARAM; i++) begin
        pend[i] <= rst_val(5'(i));
        act[i]  <= rst_val(5'(i));
      end
    end else begin
      if (do_write && (w_idx < 5'(`IOSEL_NPARAM)) && !is_factory(w_idx)) begin
        if (w_strb[0]) pend[w_idx][7:0]  <= w_data[7:0];
        if (w_strb[1]) pend[w_idx][15:8] <= w_data[15:8];
      end
      if (power_cycle) begin
        for (int i = 0; i < `IOSEL_NPARAM; i++) act[i] <= pend[i];
      end
    end
  end

  // read data, pending values so software sees what it wrote
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `IOSEL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `IOSEL_RESP_OKAY;
      if (r_idx < 5'(`IOSEL_NPARAM)) begin
        s_axi_rdata <= {16'h0000, pend[r_idx]};
      end else if (r_idx == `IOSEL_IDX_STAT) begin
        s_axi_rdata <= {25'h0, stop_state, forward_stroke_end, reverse_stroke_end,
                        reset_input, power_stage_on, ride_through_indicator};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `IOSEL_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // input filter and function mapping
  // --------------------------------------------------------------------------
  logic [8:0] tick_cnt;
  logic       tick;
  logic [6:0] di_filt;
  logic [3:0] filt_cnt [7];
  logic [3:0] filt_set;
  logic       next_fwd;
  logic       next_rev;
  logic       next_res;

  assign tick     = (tick_cnt == FILT_TICK - 9'd1);
  assign filt_set = digit(act[`IOSEL_IDX_FILT], 2'd0);

  // sampling tick divider
  always_ff @(posedge mclk) begin
    if (sys_rst || tick) tick_cnt <= 9'd0;
    else tick_cnt <= tick_cnt + 9'd1;
  end

  // a pin change is accepted once stable for the set number of ticks
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      di_filt <= 7'h00;
      for (int i = 0; i < 7; i++) filt_cnt[i] <= 4'h0;
    end else begin
      for (int i = 0; i < 7; i++) begin
        if (di_pin[i] == di_filt[i]) begin
          filt_cnt[i] <= 4'h0;
        end else if (filt_cnt[i] >= filt_set) begin
          di_filt[i]  <= di_pin[i];
          filt_cnt[i] <= 4'h0;
        end else if (tick) begin
          filt_cnt[i] <= filt_cnt[i] + 4'h1;
        end
      end
    end
  end

  // map pins to functions, low byte of each pin's low word is its code
  always_comb begin
    next_fwd = act[`IOSEL_IDX_AUTO][`IOSEL_AUTO_FWD];
    next_rev = act[`IOSEL_IDX_AUTO][`IOSEL_AUTO_REV];
    next_res = act[`IOSEL_IDX_AUTO][`IOSEL_AUTO_RES];
    for (int i = 0; i < 7; i++) begin
      if (di_filt[i]) begin
        if (act[(i == 0) ? 1 : 2 * i][7:0] == `IOSEL_FN_FWD) next_fwd = 1'b1;
        if (act[(i == 0) ? 1 : 2 * i][7:0] == `IOSEL_FN_REV) next_rev = 1'b1;
        if (act[(i == 0) ? 1 : 2 * i][7:0] == `IOSEL_FN_RES) next_res = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      forward_stroke_end <= 1'b0;
      reverse_stroke_end <= 1'b0;
      reset_input        <= 1'b0;
    end else begin
      forward_stroke_end <= next_fwd;
      reverse_stroke_end <= next_rev;
      reset_input        <= next_res;
    end
  end

  // --------------------------------------------------------------------------
  // stop processing
  // --------------------------------------------------------------------------
  logic stroke_event;
  logic slow_sel;

  assign stroke_event = !forward_stroke_end || !reverse_stroke_end || soft_limit_hit;
  assign slow_sel     = (digit(act[`IOSEL_IDX_STOP], `IOSEL_STOP_DIG_LSB) == 4'h1);

  // stop kind is chosen on entry and held until the event clears
  always_comb begin
    next_stop_state = stop_state;
    unique case (stop_state)
      iosel_pkg::IOSEL_RUN: begin
        if (stroke_event)
          next_stop_state = slow_sel ? iosel_pkg::IOSEL_SLOW : iosel_pkg::IOSEL_SUDDEN;
      end
      iosel_pkg::IOSEL_SLOW,
      iosel_pkg::IOSEL_SUDDEN: begin
        if (!stroke_event) next_stop_state = iosel_pkg::IOSEL_RUN;
      end
      default: next_stop_state = iosel_pkg::IOSEL_RUN;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) stop_state <= iosel_pkg::IOSEL_RUN;
    else stop_state <= next_stop_state;
  end

  // stop outputs and deceleration time
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stop_sudden <= 1'b0;
      stop_slow   <= 1'b0;
      decel_time  <= 16'h0000;
    end else begin
      stop_sudden <= (next_stop_state == iosel_pkg::IOSEL_SUDDEN);
      stop_slow   <= (next_stop_state == iosel_pkg::IOSEL_SLOW);
      decel_time  <= (next_stop_state == iosel_pkg::IOSEL_SLOW) ? point_decel
                                                                : 16'h0000;
    end
  end

  // --------------------------------------------------------------------------
  // power stage, ride-through indicator and output pins
  // --------------------------------------------------------------------------
  logic keep_on_reset;
  logic rti_any;
  logic next_rti;

  assign keep_on_reset = (digit(act[`IOSEL_IDX_STOP], `IOSEL_RES_DIG_LSB) == 4'h1);
  assign rti_any       = (digit(act[`IOSEL_IDX_STOP], `IOSEL_RTI_DIG_LSB) == 4'h1);
  assign next_rti      = power_fail_ride || (rti_any && overload_ride);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      power_stage_on         <= 1'b0;
      ride_through_indicator <= 1'b0;
      do_pin                 <= 4'h0;
    end else begin
      power_stage_on         <= servo_on_req && (!reset_input || keep_on_reset);
      ride_through_indicator <= next_rti;
      for (int j = 0; j < 4; j++) begin
        do_pin[j] <= (act[14 + j][3:0] == `IOSEL_RTI_CODE) ? next_rti
                                                           : status_in[act[14 + j][3:0]];
      end
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  sequence s_stop_entry;
    (stop_state == iosel_pkg::IOSEL_RUN) && stroke_event;
  endsequence

  a_reset_sudden: assert property (@(posedge mclk) disable iff (sys_rst)
    $past(sys_rst) |-> (act[`IOSEL_IDX_STOP] == 16'h0000) && !slow_sel)
    else $error("stop select not sudden after reset");
  a_power_cycle_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    !power_cycle |=> act[`IOSEL_IDX_STOP] == $past(act[`IOSEL_IDX_STOP]))
    else $error("live word changed without power cycle");
  a_power_cycle_load: assert property (@(posedge mclk) disable iff (sys_rst)
    power_cycle |=> act[`IOSEL_IDX_FILT] == $past(pend[`IOSEL_IDX_FILT]))
    else $error("power cycle did not load pending word");
  a_factory_kept: assert property (@(posedge mclk) disable iff (sys_rst)
    pend[`IOSEL_IDX_FACA] == 16'h0000)
    else $error("factory word changed");
  a_stop_kind: assert property (@(posedge mclk) disable iff (sys_rst)
    s_stop_entry ##0 slow_sel |=> stop_state == iosel_pkg::IOSEL_SLOW)
    else $error("wrong stop kind");
  a_sudden_decel: assert property (@(posedge mclk) disable iff (sys_rst)
    s_stop_entry ##0 !slow_sel |=> stop_sudden && (decel_time == 16'h0000))
    else $error("sudden stop with nonzero deceleration");
  a_slow_decel: assert property (@(posedge mclk) disable iff (sys_rst)
    (next_stop_state == iosel_pkg::IOSEL_SLOW) |=> stop_slow &&
      (decel_time == $past(point_decel)))
    else $error("slow stop deceleration wrong");
  a_base_off: assert property (@(posedge mclk) disable iff (sys_rst)
    reset_input && !keep_on_reset |=> !power_stage_on)
    else $error("power stage on during reset");
  a_ride_select: assert property (@(posedge mclk) disable iff (sys_rst)
    overload_ride && !power_fail_ride |=> ride_through_indicator == $past(rti_any))
    else $error("ride-through indicator selection wrong");
  a_out_map: assert property (@(posedge mclk) disable iff (sys_rst)
    (act[14][3:0] != `IOSEL_RTI_CODE) |=> do_pin[0] == $past(status_in[act[14][3:0]]))
    else $error("output pin one not mapped");

endmodule // iosel_top

/* File: tb/iosel_host_model.sv */
// host controller model that drives the digital pins and drive status
`timescale 1ns/1ns
module iosel_host_model (
  // clock
  input  wire logic       mclk,
  // levels requested by the bench
  input  wire logic [6:0] want_di,
  input  wire logic [4:0] want_flags,
  // pins and status towards the drive
  output logic [6:0]      di_pin,
  output logic            power_cycle,
  output logic            soft_limit_hit,
  output logic            servo_on_req,
  output logic            overload_ride,
  output logic            power_fail_ride
);
  // levels move just after an edge and then hold, one driver per output
  always @(posedge mclk) begin
    di_pin <= want_di;
    {soft_limit_hit, servo_on_req, overload_ride, power_fail_ride} <= want_flags[3:0];
    power_cycle <= want_flags[4]; // off/on cycle makes new words valid
  end
endmodule // iosel_host_model

/* File: tb/io_setting_and_stop_select_tb.sv */
// self-checking bench of the i/o setting and stop select block
`timescale 1ns/1ns
`include "iosel_consts.svh"
module io_setting_and_stop_select_tb;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_VAL [26] = '{16'h0000, 16'h262d, 16'h0303, 16'h2003,
    16'h0202, 16'h0202, 16'h0d06, 16'h2c0d, 16'h070a, 16'h0707, 16'h080b, 16'h0808,
    16'h0505, 16'h0505, 16'h0003, 16'h0004, 16'h0002, 16'h0005, 16'h0002, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] STOP_CASE [5] = '{16'h0000, 16'h0001, 16'h0010, 16'h0100, 16'h0111};
  localparam logic [3:0]  OUT_CODE [4] = '{4'h3, 4'h4, 4'h2, 4'h5};
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0, do_pin, oc0 = 4'h3;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [6:0]  want_di = 7'h00, di_pin;
  logic [4:0]  want_flags = 5'h00;
  logic        power_cycle, soft_limit_hit, servo_on_req, overload_ride, power_fail_ride;
  logic [15:0] status_in = 16'h0, point_decel = 16'h0, decel_time, live = 16'h0;
  logic        forward_stroke_end, reverse_stroke_end, reset_input, stop_sudden, stop_slow;
  logic        power_stage_on, ride_through_indicator;
  int          failures = 0;
  int          cmp_count = 0;
  // clock of 4 ns
  initial begin
    forever #2 mclk = ~mclk;
  end
  // block under test and the host on its pins
  iosel_top i_dut (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_cycle, .di_pin, .do_pin,
    .soft_limit_hit, .servo_on_req, .overload_ride, .power_fail_ride, .status_in,
    .point_decel, .forward_stroke_end, .reverse_stroke_end, .reset_input, .stop_sudden,
    .stop_slow, .decel_time, .power_stage_on, .ride_through_indicator);
  iosel_host_model i_host (.mclk, .want_di, .want_flags, .di_pin, .power_cycle,
    .soft_limit_hit, .servo_on_req, .overload_ride, .power_fail_ride);
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic wrap_up();
    $display("counts: %0d compares, %0d mismatches", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one write, address and data offered together, bready held until bvalid
  task automatic reg_wr(input logic [5:0] idx, input logic [31:0] d);
    int n;
    @(posedge mclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 100) begin
      failures++;
      wrap_up();
    end
    check(32'(s_axi_bresp), 32'(`IOSEL_RESP_OKAY));
  endtask
  // one read, compared with the expected word and response
  task automatic reg_chk(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge mclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 100) begin
      failures++;
      wrap_up();
    end
    check(s_axi_rdata, exp);
    check(32'(s_axi_rresp), 32'(er));
  endtask
  // new pin and status levels, then let them settle
  task automatic drive(input logic [6:0] d, input logic [3:0] f, input logic [15:0] s,
                       input logic [15:0] p);
    want_di <= d;
    want_flags <= {1'b0, f};
    status_in <= s;
    point_decel <= p;
    repeat (8) @(posedge mclk);
  endtask
  // power off and on again
  task automatic pcycle();
    want_flags[4] <= 1'b1;
    @(posedge mclk);
    want_flags[4] <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
  // every drive side output against the levels and the live stop word
  task automatic check_pins();
    logic       ev, sl, r;
    logic [3:0] c;
    int         j;
    ev = !want_di[4] || !want_di[5] || want_flags[3];
    sl = ev && live[3:0] == 4'h1;
    r = want_flags[0] || (live[11:8] == 4'h1 && want_flags[1]);
    check(32'({reverse_stroke_end, forward_stroke_end, reset_input}),
          32'(want_di[5:3]));
    check(32'({stop_sudden, stop_slow}), 32'({ev && !sl, sl}));
    check(32'(decel_time), 32'(sl ? point_decel : 16'h0000));
    check(32'(power_stage_on),
          32'(want_flags[2] && (!want_di[3] || live[7:4] == 4'h1)));
    check(32'(ride_through_indicator), 32'(r));
    for (j = 0; j < 4; j++) begin
      c = (j == 0) ? oc0 : OUT_CODE[j];
      check(32'(do_pin[j]), 32'((c == 4'hf) ? r : status_in[c]));
    end
  endtask
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    int          i;
    int          k;
    logic [15:0] w;
    i = $urandom(32'hfc3f);
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    for (i = 0; i < 26; i++) begin
      reg_chk(6'(i), {16'h0, RST_VAL[i]}, `IOSEL_RESP_OKAY);
    end
    reg_chk(6'd27, 32'h0, `IOSEL_RESP_SLVERR);
    check_pins();
    // status word: sudden stop state in bits 6:5, all drive flags low
    reg_chk(6'd26, 32'h0000_0040, `IOSEL_RESP_OKAY);
    $display("test reset values done");
    for (k = 0; k < 4; k++) begin
      i = (k == 3) ? 25 : 20 + 2 * k;
      reg_wr(6'(i), 32'h0000_ffff);
      reg_chk(6'(i), 32'h0, `IOSEL_RESP_OKAY);
    end
    reg_wr(6'd13, 32'habcd_5aa5);
    reg_chk(6'd13, 32'h0000_5aa5, `IOSEL_RESP_OKAY);
    $display("test factory words and upper bits done");
    reg_wr(6'd18, 32'h0);
    reg_wr(6'd6, 32'h0d0d);
    reg_wr(6'd14, 32'h000f);
    reg_wr(6'd19, 32'h0001);
    check_pins();
    pcycle();
    oc0 = 4'hf;
    for (k = 0; k < 6; k++) begin
      w = (k < 5) ? STOP_CASE[k] : 16'($urandom) & 16'h0333;
      reg_wr(6'd19, {16'h0, w});
      reg_chk(6'd19, {16'h0, w}, `IOSEL_RESP_OKAY);
      pcycle();
      live = w;
      for (i = 0; i < 12; i++) begin
        drive(7'h30, 4'h4, 16'($urandom), 16'($urandom));
        check_pins();
        drive(7'($urandom), 4'($urandom), 16'($urandom), 16'($urandom));
        check_pins();
      end
      $display("test stop word %h done", w);
    end
    wrap_up();
  end
endmodule // io_setting_and_stop_select_tb
